// >>> core/mon_pkg.sv
// package: register map, bus codes and timing constants
`default_nettype none
package mon_pkg;
  localparam logic [7:0] MON_PTR_SETUP = 8'h00;
  localparam logic [7:0] MON_PTR_SHUNT = 8'h01;
  localparam logic [7:0] MON_PTR_RAIL = 8'h02;
  localparam logic [7:0] MON_PTR_POWER = 8'h03;
  localparam logic [7:0] MON_PTR_CURRENT = 8'h04;
  localparam logic [15:0] MON_SETUP_RESET = 16'h4127;
  localparam logic [15:0] MON_RESULT_RESET = 16'h0000;
  localparam int MON_SETUP_RST_BIT = 15;
  localparam logic [4:0] MON_HS_CODE = 5'h01;
  localparam logic [6:0] MON_ARA_ADDR = 7'h0C;
  localparam logic [2:0] MON_ADDR_BASE = 3'h4;
  localparam int MON_CLK_HZ = 20000000;
  localparam int MON_TIMEOUT_MS = 28;
  localparam int MON_TIMEOUT_CYC = MON_CLK_HZ / 1000 * MON_TIMEOUT_MS;
  typedef enum logic [1:0] {
    MON_PIN_GND, MON_PIN_VS, MON_PIN_SDA, MON_PIN_SCL
  } mon_pin_t;
endpackage : mon_pkg
`default_nettype wire

// >>> core/mon_line_if.sv
// interface: synchronised bus line events from the front end
`default_nettype none
interface mon_line_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  modport front (output scl, sda, scl_rise, scl_fall, start, stop);
  modport core (input scl, sda, scl_rise, scl_fall, start, stop);
endinterface : mon_line_if
`default_nettype wire

// >>> core/mon_line_sync.sv
// front end: two-flop synchronisers and bus condition detection
`default_nettype none
module mon_line_sync (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  mon_line_if.front ln
);
  logic [1:0] scl_s_q, scl_s_d, sda_s_q, sda_s_d;
  logic scl_p_q, scl_p_d, sda_p_q, sda_p_d;
  always_comb begin
    scl_s_d = {scl_s_q[0], scl_i};
    sda_s_d = {sda_s_q[0], sda_i};
    scl_p_d = scl_s_q[1];
    sda_p_d = sda_s_q[1];
  end
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_s_q <= scl_s_d;
      sda_s_q <= sda_s_d;
      scl_p_q <= scl_p_d;
      sda_p_q <= sda_p_d;
    end
  end
  assign ln.scl = scl_p_q;
  assign ln.sda = sda_p_q;
  assign ln.scl_rise = scl_s_q[1] & ~scl_p_q;
  assign ln.scl_fall = ~scl_s_q[1] & scl_p_q;
  assign ln.start = scl_s_q[1] & scl_p_q & sda_p_q & ~sda_s_q[1];
  assign ln.stop = scl_s_q[1] & scl_p_q & ~sda_p_q & sda_s_q[1];
endmodule : mon_line_sync
`default_nettype wire

// >>> core/mon_i2c_target.sv
// main: two-wire target with high-speed mode, alert response, registers
// Function
// - high-speed code is never acknowledged but switches filters
// - after repeated start, normal byte protocol continues at high speed
// - stop leaves high speed and restores standard filters
// - pending alert: acknowledge alert read, then send own address
// - lost arbitration: no acknowledge, alert held until cleared
// - every register moves as two consecutive bytes
// - pointer 0 is read/write setup register, reset 4127h
// - pointers 1 to 4 are read-only results, zero at reset
// - power and current read zero while calibration is zero
// - write: pointer byte, then two data bytes, each acknowledged
// - read returns pointed register high byte first; pointer kept
// - address pins sampled every transaction to form the address
// - stalled transaction released after 28 ms timeout
`default_nettype none
module mon_i2c_target
  import mon_pkg::*;
#(
  parameter int TIMEOUT_CYC = MON_TIMEOUT_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [1:0] addr_select_pin_low_i,
  input wire logic [1:0] addr_select_pin_high_i,
  input wire logic alert_pend_i,
  output logic alert_clr_o,
  input wire logic [15:0] calibration_i,
  input wire logic [15:0] shunt_i,
  input wire logic [15:0] rail_i,
  input wire logic [15:0] power_i,
  input wire logic [15:0] current_i,
  output logic [15:0] setup_o,
  output logic setup_wr_o,
  output logic hs_mode_o
);
  if (TIMEOUT_CYC < 2) begin : g_bad_timeout
    $error("timeout too short");
  end
  mon_line_if ln ();
  mon_line_sync u_sync (
    .mclk_i(mclk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .ln(ln)
  );
  typedef enum logic [2:0] {
    MON_IDLE, MON_RX, MON_ACK, MON_TX, MON_MACK
  } mon_st_t;
  typedef enum logic [1:0] {
    MON_K_ADDR, MON_K_PTR, MON_K_DATA
  } mon_kind_t;
  mon_st_t st_q, st_d;
  mon_kind_t kind_q, kind_d;
  logic [7:0] sh_q, sh_d;
  logic [3:0] bit_q, bit_d;
  logic ack_q, ack_d;
  logic rd_q, rd_d;
  logic ara_q, ara_d;
  logic lsb_q, lsb_d;
  logic [7:0] ptr_q, ptr_d;
  logic [7:0] hi_q, hi_d;
  logic [15:0] setup_q, setup_d;
  logic hs_q, hs_d;
  logic drv_q, drv_d;
  logic [6:0] my_addr_q, my_addr_d;
  logic [31:0] to_q, to_d;
  logic wr_q, wr_d;
  logic clr_q, clr_d;
  logic [15:0] rdata;
  logic [7:0] rx_byte;
  logic [6:0] live_addr;
  function automatic logic [1:0] pin_code(input logic [1:0] p);
    pin_code = p;
  endfunction : pin_code
  // address pins: GND/VS/SDA/SCL straps map onto low address bits
  assign live_addr = {MON_ADDR_BASE, pin_code(addr_select_pin_high_i),
    pin_code(addr_select_pin_low_i)};
  assign rx_byte = {sh_q[6:0], ln.sda};
  always_comb begin
    case (ptr_q)
      MON_PTR_SETUP: rdata = setup_q;
      MON_PTR_SHUNT: rdata = shunt_i;
      MON_PTR_RAIL: rdata = rail_i;
      MON_PTR_POWER: rdata = (calibration_i == 16'h0000) ?
        MON_RESULT_RESET : power_i;
      MON_PTR_CURRENT: rdata = (calibration_i == 16'h0000) ?
        MON_RESULT_RESET : current_i;
      default: rdata = 16'h0000;
    endcase
  end
  always_comb begin
    st_d = st_q;
    kind_d = kind_q;
    sh_d = sh_q;
    bit_d = bit_q;
    ack_d = ack_q;
    rd_d = rd_q;
    ara_d = ara_q;
    lsb_d = lsb_q;
    ptr_d = ptr_q;
    hi_d = hi_q;
    setup_d = setup_q;
    hs_d = hs_q;
    drv_d = drv_q;
    my_addr_d = my_addr_q;
    wr_d = 1'b0;
    clr_d = 1'b0;
    to_d = (st_q == MON_IDLE || ln.scl_rise || ln.scl_fall) ? 32'h0 :
      to_q + 32'h1;
    if (ln.stop) begin
      st_d = MON_IDLE;
      hs_d = 1'b0;
      drv_d = 1'b0;
    end else if (ln.start) begin
      st_d = MON_RX;
      kind_d = MON_K_ADDR;
      bit_d = 4'h0;
      drv_d = 1'b0;
      my_addr_d = live_addr;
    end else if (st_q != MON_IDLE && to_q >= 32'(TIMEOUT_CYC - 1)) begin
      st_d = MON_IDLE;
      drv_d = 1'b0;
    end else begin
      case (st_q)
        MON_RX: begin
          if (ln.scl_rise) begin
            sh_d = rx_byte;
            bit_d = bit_q + 4'h1;
          end
          if (ln.scl_fall && bit_q == 4'h8) begin
            st_d = MON_ACK;
            ack_d = 1'b0;
            if (kind_q == MON_K_ADDR) begin
              rd_d = sh_q[0];
              ara_d = 1'b0;
              lsb_d = 1'b0;
              if (sh_q[7:3] == MON_HS_CODE) begin
                hs_d = 1'b1;
              end else if (sh_q[7:1] == my_addr_q) begin
                ack_d = 1'b1;
              end else if (sh_q[7:1] == MON_ARA_ADDR && sh_q[0] &&
                  alert_pend_i) begin
                ack_d = 1'b1;
                ara_d = 1'b1;
              end
            end else if (kind_q == MON_K_PTR) begin
              ack_d = 1'b1;
              ptr_d = sh_q;
            end else begin
              ack_d = 1'b1;
              if (!lsb_q) begin
                hi_d = sh_q;
                lsb_d = 1'b1;
              end else begin
                lsb_d = 1'b0;
                if (ptr_q == MON_PTR_SETUP) begin
                  setup_d = {hi_q, sh_q};
                  wr_d = 1'b1;
                  if (hi_q[MON_SETUP_RST_BIT - 8]) begin
                    setup_d = MON_SETUP_RESET;
                  end
                end
              end
            end
            drv_d = ack_d;
          end
        end
        MON_ACK: begin
          if (ln.scl_fall) begin
            bit_d = 4'h0;
            if (!ack_q) begin
              st_d = MON_IDLE;
              drv_d = 1'b0;
            end else if (rd_q && kind_q == MON_K_ADDR) begin
              st_d = MON_TX;
              sh_d = ara_q ? {my_addr_q, 1'b0} : rdata[15:8];
              hi_d = rdata[7:0];
              drv_d = ~(ara_q ? my_addr_q[6] : rdata[15]);
            end else begin
              st_d = MON_RX;
              kind_d = (kind_q == MON_K_ADDR) ? MON_K_PTR : MON_K_DATA;
              drv_d = 1'b0;
            end
          end
        end
        MON_TX: begin
          if (ln.scl_rise && !drv_q && !ln.sda) begin
            st_d = MON_IDLE;
            drv_d = 1'b0;
          end else if (ln.scl_fall) begin
            sh_d = {sh_q[6:0], 1'b0};
            bit_d = bit_q + 4'h1;
            if (bit_q == 4'h7) begin
              st_d = MON_MACK;
              drv_d = 1'b0;
              if (ara_q) begin
                clr_d = 1'b1;
              end
            end else begin
              drv_d = ~sh_q[6];
            end
          end
        end
        MON_MACK: begin
          if (ln.scl_rise && ln.sda) begin
            st_d = MON_IDLE;
          end else if (ln.scl_fall) begin
            st_d = MON_TX;
            bit_d = 4'h0;
            sh_d = ara_q ? 8'hFF : hi_q;
            hi_d = ara_q ? 8'hFF : rdata[15:8];
            drv_d = ara_q ? 1'b0 : ~hi_q[7];
          end
        end
        default: st_d = MON_IDLE;
      endcase
    end
  end
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_q <= MON_IDLE;
      kind_q <= MON_K_ADDR;
      sh_q <= 8'h00;
      bit_q <= 4'h0;
      ack_q <= 1'b0;
      rd_q <= 1'b0;
      ara_q <= 1'b0;
      lsb_q <= 1'b0;
      ptr_q <= MON_PTR_SETUP;
      hi_q <= 8'h00;
      setup_q <= MON_SETUP_RESET;
      hs_q <= 1'b0;
      drv_q <= 1'b0;
      my_addr_q <= {MON_ADDR_BASE, 4'h0};
      to_q <= 32'h0;
      wr_q <= 1'b0;
      clr_q <= 1'b0;
    end else begin
      st_q <= st_d;
      kind_q <= kind_d;
      sh_q <= sh_d;
      bit_q <= bit_d;
      ack_q <= ack_d;
      rd_q <= rd_d;
      ara_q <= ara_d;
      lsb_q <= lsb_d;
      ptr_q <= ptr_d;
      hi_q <= hi_d;
      setup_q <= setup_d;
      hs_q <= hs_d;
      drv_q <= drv_d;
      my_addr_q <= my_addr_d;
      to_q <= to_d;
      wr_q <= wr_d;
      clr_q <= clr_d;
    end
  end
  assign sda_o = 1'b0;
  assign sda_oe_o = drv_q;
  assign setup_o = setup_q;
  assign setup_wr_o = wr_q;
  assign hs_mode_o = hs_q;
  assign alert_clr_o = clr_q;

  property p_hs_exit;
    @(posedge mclk_i) disable iff (rst_i) ln.stop |=> !hs_q;
  endproperty
  a_hs_exit: assert property (p_hs_exit) else $error("hs after stop");
  property p_hs_noack;
    @(posedge mclk_i) disable iff (rst_i)
      $rose(hs_q) |-> ##1 !sda_oe_o;
  endproperty
  a_hs_noack: assert property (p_hs_noack) else $error("hs code acked");
  property p_timeout;
    @(posedge mclk_i) disable iff (rst_i)
      (to_q >= 32'(TIMEOUT_CYC - 1) && !ln.start && !ln.stop)
      |=> st_q == MON_IDLE && !sda_oe_o;
  endproperty
  a_timeout: assert property (p_timeout) else $error("no timeout");
  property p_ro_keep;
    @(posedge mclk_i) disable iff (rst_i)
      ptr_q != MON_PTR_SETUP |=> $stable(setup_q);
  endproperty
  a_ro_keep: assert property (p_ro_keep) else $error("ro write");
  property p_cal_zero;
    @(posedge mclk_i) disable iff (rst_i)
      (calibration_i == 16'h0000 && (ptr_q == MON_PTR_POWER ||
      ptr_q == MON_PTR_CURRENT)) |-> rdata == 16'h0000;
  endproperty
  a_cal_zero: assert property (p_cal_zero) else $error("cal zero");
  property p_ptr_keep;
    @(posedge mclk_i) disable iff (rst_i)
      (st_q != MON_RX || kind_q != MON_K_PTR) |=> $stable(ptr_q);
  endproperty
  a_ptr_keep: assert property (p_ptr_keep) else $error("ptr moved");
  property p_addr_sample;
    @(posedge mclk_i) disable iff (rst_i)
      ln.start |=> my_addr_q == $past(live_addr);
  endproperty
  a_addr_sample: assert property (p_addr_sample) else $error("addr");
  property p_wr_pair;
    @(posedge mclk_i) disable iff (rst_i)
      setup_wr_o |-> $past(ptr_q) == MON_PTR_SETUP && !lsb_q;
  endproperty
  a_wr_pair: assert property (p_wr_pair) else $error("bad write");
endmodule : mon_i2c_target
`default_nettype wire

// >>> dv/mon_ctrl_model.sv
// controller model: drives serial clock and pulls the data line low
`default_nettype none
module mon_ctrl_model (
  input wire logic mclk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_pull_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : tick
  // one bit, 400 ns clock period, data moved in low phase
  task automatic bit_io(input logic b, output logic r);
    tick(1);
    sda_pull_o <= ~b;
    tick(3);
    scl_o <= 1'b1;
    tick(2);
    r = sda_i;
    tick(2);
    scl_o <= 1'b0;
  endtask : bit_io
  // start or repeated start
  task automatic start();
    tick(1);
    sda_pull_o <= 1'b0;
    tick(3);
    scl_o <= 1'b1;
    tick(4);
    sda_pull_o <= 1'b1;
    tick(4);
    scl_o <= 1'b0;
  endtask : start
  task automatic stop();
    tick(1);
    sda_pull_o <= 1'b1;
    tick(3);
    scl_o <= 1'b1;
    tick(4);
    sda_pull_o <= 1'b0;
    tick(4);
  endtask : stop
  // byte out msb first, then ack bit; 1 in d releases the line
  task automatic xfer(input logic [7:0] d, input logic ai,
                      output logic [7:0] q, output logic ak);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ai, ak);
  endtask : xfer
endmodule : mon_ctrl_model
`default_nettype wire

// >>> dv/monitor_i2c_hs_alert_regs_tb_top.sv
// testbench: registers, high speed, alert response and timeout
`default_nettype none
module monitor_i2c_hs_alert_regs_tb_top;
  import mon_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TO = 200;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic scl, pull, sda, sda_o, sda_oe_o, alert_clr_o, setup_wr_o, hs_mode_o;
  logic [1:0] lo = 2'h0;
  logic [1:0] hi = 2'h0;
  logic alert = 1'b0;
  logic [15:0] cal = 16'h0000;
  logic [15:0] sh = 16'h0000;
  logic [15:0] ra = 16'h0000;
  logic [15:0] pw = 16'h0000;
  logic [15:0] cu = 16'h0000;
  logic [15:0] setup_o;
  int err_count = 0;
  int checked = 0;
  int seed = 94428;
  int cyc = 0;
  int clr_n = 0;
  int wr_n = 0;
  assign sda = ~(pull | (sda_oe_o & ~sda_o));
  mon_i2c_target #(.TIMEOUT_CYC(TO)) u_mon_i2c_target (.mclk_i(mclk_i),
    .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .addr_select_pin_low_i(lo),
    .addr_select_pin_high_i(hi), .alert_pend_i(alert),
    .alert_clr_o(alert_clr_o), .calibration_i(cal), .shunt_i(sh),
    .rail_i(ra), .power_i(pw), .current_i(cu), .setup_o(setup_o),
    .setup_wr_o(setup_wr_o), .hs_mode_o(hs_mode_o));
  mon_ctrl_model u_mon_ctrl_model (.mclk_i(mclk_i), .sda_i(sda),
    .scl_o(scl), .sda_pull_o(pull));
  initial begin
    forever #25 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (alert_clr_o === 1'b1) clr_n <= clr_n + 1;
    if (setup_wr_o === 1'b1) wr_n <= wr_n + 1;
    if (cyc == 60000) begin
      err_count = err_count + 1;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  task automatic check(input string nm, input logic [15:0] s, e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  function automatic logic [6:0] own();
    return {MON_ADDR_BASE, hi, lo};
  endfunction : own
  function automatic logic [15:0] res(input logic [7:0] p);
    case (p)
      8'h01: return sh;
      8'h02: return ra;
      8'h03: return (cal == 16'h0000) ? 16'h0000 : pw;
      default: return (cal == 16'h0000) ? 16'h0000 : cu;
    endcase
  endfunction : res
  task automatic wr(input logic [7:0] p, input logic [15:0] v, input int n);
    logic [7:0] q;
    logic [3:0] a;
    a = 4'h0;
    u_mon_ctrl_model.start();
    u_mon_ctrl_model.xfer({own(), 1'b0}, 1'b1, q, a[0]);
    u_mon_ctrl_model.xfer(p, 1'b1, q, a[1]);
    if (n > 0) begin
      u_mon_ctrl_model.xfer(v[15:8], 1'b1, q, a[2]);
      u_mon_ctrl_model.xfer(v[7:0], 1'b1, q, a[3]);
    end
    check("write acks", {12'h000, a}, 16'h0000);
  endtask : wr
  task automatic rd(input logic [15:0] e);
    logic [7:0] m;
    logic [7:0] l;
    logic k;
    u_mon_ctrl_model.start();
    u_mon_ctrl_model.xfer({own(), 1'b1}, 1'b1, m, k);
    u_mon_ctrl_model.xfer(8'hFF, 1'b0, m, k);
    u_mon_ctrl_model.xfer(8'hFF, 1'b1, l, k);
    u_mon_ctrl_model.stop();
    check("read word", {m, l}, e);
  endtask : rd
  task automatic ara(input logic [7:0] d, output logic [7:0] q,
                     output logic k);
    logic [7:0] x;
    u_mon_ctrl_model.start();
    u_mon_ctrl_model.xfer(8'h19, 1'b1, x, k);
    if (k === 1'b0) u_mon_ctrl_model.xfer(d, 1'b1, q, x[0]);
    u_mon_ctrl_model.stop();
  endtask : ara
  initial begin
    logic [15:0] v;
    logic [7:0] q;
    logic k;
    int c;
    logic [7:0] b;
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    check("setup", setup_o, MON_SETUP_RESET);
    check("hs", {15'h0, hs_mode_o}, 16'h0000);
    rd(MON_SETUP_RESET);
    wr(MON_PTR_SHUNT, 16'h0000, 0);
    u_mon_ctrl_model.stop();
    rd(MON_RESULT_RESET);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk_i);
      {hi, lo} <= 4'($random(seed));
      v = (i == 0) ? 16'h8000 : {1'b0, 15'($random(seed))};
      c = wr_n;
      wr(MON_PTR_SETUP, v, 2);
      u_mon_ctrl_model.stop();
      check("setup pulse", 16'(wr_n), 16'(c + 1));
      if (i == 0) v = MON_SETUP_RESET;
      check("setup", setup_o, v);
      rd(v);
      rd(v);
    end
    u_mon_ctrl_model.start();
    u_mon_ctrl_model.xfer({own() ^ 7'h40, 1'b0}, 1'b1, q, k);
    u_mon_ctrl_model.stop();
    check("foreign ack", {15'h0, k}, 16'h0001);
    $display("setup test done");
    c = wr_n;
    for (int z = 0; z < 2; z++) begin
      @(posedge mclk_i);
      cal <= (z == 0) ? 16'($random(seed)) | 16'h0001 : 16'h0000;
      sh <= 16'($random(seed));
      ra <= 16'($random(seed));
      pw <= 16'($random(seed));
      cu <= 16'($random(seed));
      for (int p = 1; p <= 4; p++) begin
        wr(8'(p), 16'($random(seed)), 2);
        u_mon_ctrl_model.stop();
        rd(res(8'(p)));
      end
    end
    wr(8'h07, 16'hFFFF, 2);
    u_mon_ctrl_model.stop();
    rd(16'h0000);
    check("setup kept", setup_o, v);
    check("ro pulse", 16'(wr_n), 16'(c));
    $display("result test done");
    u_mon_ctrl_model.start();
    u_mon_ctrl_model.xfer({5'h01, 3'($random(seed))}, 1'b1, q, k);
    check("hs nack", {15'h0, k}, 16'h0001);
    check("hs", {15'h0, hs_mode_o}, 16'h0001);
    wr(MON_PTR_SETUP, 16'h0123, 2);
    wr(MON_PTR_SETUP, 16'h0456, 2);
    check("hs", {15'h0, hs_mode_o}, 16'h0001);
    u_mon_ctrl_model.stop();
    check("hs", {15'h0, hs_mode_o}, 16'h0000);
    check("setup", setup_o, 16'h0456);
    $display("high speed test done");
    alert <= 1'b1;
    c = clr_n;
    ara(8'hFF, q, k);
    check("ara ack", {15'h0, k}, 16'h0000);
    check("ara id", {8'h00, q}, {8'h00, own(), 1'b0});
    check("clear", 16'(clr_n), 16'(c + 1));
    ara(8'h00, q, k);
    check("lost clear", 16'(clr_n), 16'(c + 1));
    check("lost oe", {15'h0, sda_oe_o}, 16'h0000);
    alert <= 1'b0;
    ara(8'hFF, q, k);
    check("ara idle", {15'h0, k}, 16'h0001);
    $display("alert test done");
    u_mon_ctrl_model.start();
    b = {own(), 1'b0};
    for (int i = 7; i >= 0; i--) begin
      u_mon_ctrl_model.bit_io(b[i], k);
    end
    u_mon_ctrl_model.tick(6);
    check("stall ack", {15'h0, sda_oe_o}, 16'h0001);
    u_mon_ctrl_model.tick(TO + 20);
    check("released", {15'h0, sda_oe_o}, 16'h0000);
    u_mon_ctrl_model.stop();
    rd(16'h0456);
    $display("timeout test done");
    report_and_stop();
  end
endmodule : monitor_i2c_hs_alert_regs_tb_top
`default_nettype wire
